// ---- mtc_core.sv ----
`timescale 1ns/1ps
`include "mtc_core_regs.svh"

// Function
// - A machine cycle is exactly four system clocks and every instruction uses whole ones.
// - Ordinary instructions take one machine cycle; branch, call and table read take two.
// - Jump, subroutine enter, subroutine exit and interrupt exit each take one extra cycle.
// - Writing the program counter low byte jumps there and costs one extra cycle.
// - A conditional skip takes one cycle when not skipping and one more when it skips.
// - Conditional tests look at a data byte or one of its bits and skip the next word or not.
// - Subroutine exit resumes at the address right after the calling instruction.
// - Moves go register to accumulator, accumulator to register, or constant to accumulator.
// - Addition flags carry above 255 and subtraction flags borrow below 0.
// - Add one and subtract one change the operand by one into memory or accumulator.
// - And, or and xor combine with the accumulator, complement inverts the data byte; all set zero on a zero result.
// - Rotates move a byte one bit left or right, the carry variants passing through carry.
// - Bit set and clear read the byte, change only that bit and write it back.
// - Table read fetches constant data from program memory into a data register.
// - Add and subtract, with or without carry, update zero, carry, half carry and overflow.
module mtc_core #(
	parameter int PC_W = 10,
	parameter int STACK_DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Program memory
	output logic [PC_W-1:0] pm_addr_o,
	input wire mtc_pkg::mtc_insn_s pm_data_i,
	// Data memory
	output logic [7:0] dm_addr_o,
	output logic [7:0] dm_wdata_o,
	output logic dm_we_o,
	input wire logic [7:0] dm_rdata_i,
	// Core state
	output logic [7:0] acc_o,
	output mtc_pkg::mtc_flags_s flags_o,
	output logic [7:0] tab_hi_o,
	output logic retire_o
);

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	if (PC_W < 9 || PC_W > 10) begin : g_chk_pc
		$error("PC_W must be 9 or 10");
	end
	if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk_stk
		$error("STACK_DEPTH must be a power of two, at least 2");
	end
	if (`MTC_MC_CLOCKS != 4) begin : g_chk_mc
		$error("Phase sequencer serves four clocks per machine cycle");
	end

	////////////////////////////////////////////////////////////////////////////
	// State

	mtc_pkg::mtc_phase_e phase;
	mtc_pkg::mtc_phase_e next_phase;
	mtc_pkg::mtc_insn_s insn;
	logic [PC_W-1:0] pc;
	logic [7:0] opnd;
	logic flush;
	logic tab_pend;
	logic [15:0] tab_word;
	logic [SP_W-1:0] sp;
	logic [PC_W-1:0] stack [STACK_DEPTH];

	////////////////////////////////////////////////////////////////////////////
	// Decode

	wire mtc_pkg::mtc_op_e op = insn.op;
	wire exec_end = (phase == mtc_pkg::PH_EXEC);
	wire pc_low_sel = (insn.arg[7:0] == `MTC_PC_LOW_ADDR);
	wire is_imm = op inside {mtc_pkg::OP_ADD_X, mtc_pkg::OP_SUB_X, mtc_pkg::OP_AND_X,
		mtc_pkg::OP_OR_X, mtc_pkg::OP_XOR_X, mtc_pkg::OP_MOV_A_X};
	wire is_add = op inside {mtc_pkg::OP_ADD, mtc_pkg::OP_ADC, mtc_pkg::OP_ADD_X};
	wire is_sub = op inside {mtc_pkg::OP_SUB, mtc_pkg::OP_SBC, mtc_pkg::OP_SUB_X};
	wire is_logic = op inside {mtc_pkg::OP_AND, mtc_pkg::OP_OR, mtc_pkg::OP_XOR,
		mtc_pkg::OP_AND_X, mtc_pkg::OP_OR_X, mtc_pkg::OP_XOR_X, mtc_pkg::OP_COMPLEMENT};
	wire is_step = op inside {mtc_pkg::OP_ADD_ONE, mtc_pkg::OP_SUB_ONE};
	wire is_rot = op inside {mtc_pkg::OP_ROT_R, mtc_pkg::OP_ROT_L,
		mtc_pkg::OP_ROT_R_C, mtc_pkg::OP_ROT_L_C};
	wire is_bit = op inside {mtc_pkg::OP_SET_BIT, mtc_pkg::OP_CLR_BIT};
	wire is_exit = op inside {mtc_pkg::OP_SUB_EXIT, mtc_pkg::OP_INT_EXIT};
	wire is_call = (op == mtc_pkg::OP_CALL);
	wire is_jump = (op == mtc_pkg::OP_JUMP);
	wire is_tab = (op == mtc_pkg::OP_TAB_READ);

	// Operand paths
	wire [7:0] b = is_imm ? insn.arg[7:0] : opnd;
	wire [7:0] bit_mask = 8'h01 << insn.bsel;
	// Carry holds the borrow after a subtraction
	wire cin = (op == mtc_pkg::OP_ADC) ? flags_o.c : 1'b0;
	wire bin = (op == mtc_pkg::OP_SBC) ? flags_o.c : 1'b0;

	// Arithmetic, carry out in bit 8 and half carry in bit 4
	wire [8:0] sum9 = {1'b0, acc_o} + {1'b0, b} + {8'h00, cin};
	wire [8:0] dif9 = {1'b0, acc_o} - {1'b0, b} - {8'h00, bin};
	wire [4:0] sum_lo = {1'b0, acc_o[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	wire [4:0] dif_lo = {1'b0, acc_o[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
	wire ov_add = (acc_o[7] == b[7]) && (sum9[7] != acc_o[7]);
	wire ov_sub = (acc_o[7] != b[7]) && (dif9[7] != acc_o[7]);

	// Skip tests on the data byte or one of its bits
	wire skip_take = ((op == mtc_pkg::OP_SKIP_ZERO) && (opnd == 8'h00)) ||
		((op == mtc_pkg::OP_SKIP_BIT_CLR) && !opnd[insn.bsel]) ||
		((op == mtc_pkg::OP_SKIP_BIT_SET) && opnd[insn.bsel]);

	logic [7:0] res;
	logic wr_acc;
	logic wr_mem;
	mtc_pkg::mtc_flags_s next_flags;

	always_comb begin
		res = 8'h00;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		next_flags = flags_o;
		unique case (op)
			mtc_pkg::OP_MOV_A_M: begin
				res = opnd;
				wr_acc = 1'b1;
			end
			mtc_pkg::OP_MOV_M_A: begin
				res = acc_o;
				wr_mem = 1'b1;
			end
			mtc_pkg::OP_MOV_A_X: begin
				res = insn.arg[7:0];
				wr_acc = 1'b1;
			end
			mtc_pkg::OP_ADD, mtc_pkg::OP_ADC, mtc_pkg::OP_ADD_X: res = sum9[7:0];
			mtc_pkg::OP_SUB, mtc_pkg::OP_SBC, mtc_pkg::OP_SUB_X: res = dif9[7:0];
			mtc_pkg::OP_AND, mtc_pkg::OP_AND_X: res = acc_o & b;
			mtc_pkg::OP_OR, mtc_pkg::OP_OR_X: res = acc_o | b;
			mtc_pkg::OP_XOR, mtc_pkg::OP_XOR_X: res = acc_o ^ b;
			mtc_pkg::OP_COMPLEMENT: res = ~opnd;
			mtc_pkg::OP_ADD_ONE: res = opnd + 8'h01;
			mtc_pkg::OP_SUB_ONE: res = opnd - 8'h01;
			mtc_pkg::OP_ROT_R: res = {opnd[0], opnd[7:1]};
			mtc_pkg::OP_ROT_L: res = {opnd[6:0], opnd[7]};
			mtc_pkg::OP_ROT_R_C: begin
				res = {flags_o.c, opnd[7:1]};
				next_flags.c = opnd[0];
			end
			mtc_pkg::OP_ROT_L_C: begin
				res = {opnd[6:0], flags_o.c};
				next_flags.c = opnd[7];
			end
			mtc_pkg::OP_SET_BIT: res = opnd | bit_mask;
			mtc_pkg::OP_CLR_BIT: res = opnd & ~bit_mask;
			mtc_pkg::OP_CLR: begin
				res = 8'h00;
				wr_mem = 1'b1;
			end
			default: res = 8'h00;
		endcase
		// Memory forms write back unless steered into the accumulator; bit set and clear always write back
		if (is_add || is_sub || is_logic || is_step || is_rot || is_bit) begin
			wr_acc = insn.to_acc && !is_bit;
			wr_mem = !insn.to_acc || is_bit;
		end
		// Immediate forms always land in the accumulator
		if (is_imm) begin
			wr_acc = 1'b1;
			wr_mem = 1'b0;
		end
		if (is_add || is_sub) begin
			next_flags.z = (res == 8'h00);
			next_flags.c = is_add ? sum9[8] : dif9[8];
			next_flags.ac = is_add ? sum_lo[4] : dif_lo[4];
			next_flags.ov = is_add ? ov_add : ov_sub;
		end
		if (is_logic || is_step) begin
			next_flags.z = (res == 8'h00);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Program flow

	wire pc_low_write = wr_mem && pc_low_sel;
	// Any change of flow costs a second machine cycle
	wire two_cycle = is_jump || is_call || is_exit || is_tab || skip_take || pc_low_write;
	wire [SP_W-1:0] sp_top = sp - SP_W'(1);
	wire [PC_W-1:0] pc_inc = pc + PC_W'(1);
	wire [PC_W-1:0] tab_addr = {{(PC_W-8){1'b1}}, acc_o}; // Tables sit in the last page

	logic [PC_W-1:0] next_pc;

	assign next_pc = (is_jump || is_call) ? insn.arg[PC_W-1:0] :
		is_exit ? stack[sp_top] :
		pc_low_write ? {pc[PC_W-1:8], res} :
		skip_take ? pc + PC_W'(2) : pc_inc;

	assign next_phase = (phase == mtc_pkg::PH_FETCH) ? mtc_pkg::PH_DECODE :
		(phase == mtc_pkg::PH_DECODE) ? mtc_pkg::PH_OPERAND :
		(phase == mtc_pkg::PH_OPERAND) ? mtc_pkg::PH_EXEC : mtc_pkg::PH_FETCH;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase <= mtc_pkg::PH_FETCH;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			insn <= '0;
			tab_word <= 16'h0000;
			dm_addr_o <= 8'h00;
			opnd <= 8'h00;
		end else begin
			// A discarded cycle never replaces the instruction or its address
			if (phase == mtc_pkg::PH_FETCH && !flush) begin
				insn <= pm_data_i;
			end
			if (phase == mtc_pkg::PH_FETCH && tab_pend) begin
				tab_word <= pm_data_i[`MTC_TAB_HI_MSB:0];
			end
			if (phase == mtc_pkg::PH_DECODE && !flush) begin
				dm_addr_o <= insn.arg[7:0];
			end
			if (phase == mtc_pkg::PH_OPERAND && !flush) begin
				opnd <= pc_low_sel ? pc[7:0] : dm_rdata_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc <= PC_W'(`MTC_PC_RST);
			pm_addr_o <= PC_W'(`MTC_PC_RST);
			acc_o <= `MTC_ACC_RST;
			flags_o <= `MTC_FLAGS_RST;
			flush <= 1'b0;
			tab_pend <= 1'b0;
			sp <= '0;
			dm_we_o <= 1'b0;
			dm_wdata_o <= 8'h00;
			tab_hi_o <= 8'h00;
			retire_o <= 1'b0;
		end else begin
			dm_we_o <= 1'b0;
			retire_o <= 1'b0;
			if (exec_end && flush) begin
				// Second cycle: the prefetched word is dropped, fetch resumes at pc
				flush <= 1'b0;
				pm_addr_o <= pc;
				retire_o <= 1'b1;
				tab_pend <= 1'b0;
				if (tab_pend) begin
					tab_hi_o <= tab_word[`MTC_TAB_HI_MSB:`MTC_TAB_HI_LSB];
					dm_we_o <= !pc_low_sel;
					dm_wdata_o <= tab_word[`MTC_TAB_LO_MSB:0];
				end
			end else if (exec_end) begin
				pc <= next_pc;
				flags_o <= next_flags;
				flush <= two_cycle;
				tab_pend <= is_tab;
				retire_o <= !two_cycle;
				// Extra cycle fetches the stale next word, or the table word
				pm_addr_o <= is_tab ? tab_addr : (two_cycle ? pc_inc : next_pc);
				if (wr_acc) begin
					acc_o <= res;
				end
				// Low counter byte lives in the core, not in data memory
				if (wr_mem && !pc_low_sel) begin
					dm_we_o <= 1'b1;
					dm_wdata_o <= res;
				end
				if (is_call) begin
					sp <= sp + SP_W'(1);
				end else if (is_exit) begin
					sp <= sp_top;
				end
			end
		end
	end

	// Return stack, one register per level
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				stack[i] <= '0;
			end else if (exec_end && !flush && is_call && sp == SP_W'(i)) begin
				stack[i] <= pc_inc;
			end
		end
	end

endmodule // mtc_core

// ---- mtc_core_props.sv ----
`timescale 1ns/1ps
module mtc_core_props #(
	parameter int PC_W = 10
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Watched outputs
	input wire logic [PC_W-1:0] pm_addr_o,
	input wire logic [7:0] dm_addr_o,
	input wire logic dm_we_o,
	input wire logic [7:0] acc_o,
	input wire mtc_pkg::mtc_flags_s flags_o,
	input wire logic [7:0] tab_hi_o,
	input wire logic retire_o
);
	// Clocks since last retire; only a hung core makes it wrap
	logic [3:0] cnt;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
		end else begin
			cnt <= retire_o ? 4'h1 : cnt + 4'h1;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_cycle_len: assert property (retire_o |-> (cnt == 4'h4 || cnt == 4'h8))
		else $error("instruction length is not one or two machine cycles");
	a_retire_gap: assert property (retire_o |=> !retire_o [*3])
		else $error("retire pulses closer than one machine cycle");
	a_write_slot: assert property (dm_we_o |-> retire_o && dm_addr_o != 8'h02)
		else $error("data write outside retire or to program counter low");
	a_fetch_step: assert property ($changed(pm_addr_o) |-> (cnt == 4'h4 || cnt == 4'h8))
		else $error("fetch address moved inside a machine cycle");
	a_flags_hold: assert property ($changed(flags_o) |-> retire_o)
		else $error("flags changed without a retire");
	a_acc_hold: assert property ($changed(acc_o) |-> retire_o)
		else $error("accumulator changed without a retire");
	a_table_slot: assert property ($changed(tab_hi_o) |-> retire_o && cnt == 4'h8)
		else $error("table high byte changed outside a two cycle retire");
	a_operand_slot: assert property ($changed(dm_addr_o) |-> cnt == 4'h2)
		else $error("data address moved outside decode end");
	c_long_op: cover property (retire_o && cnt == 4'h8);
	c_mem_write: cover property (dm_we_o);
	c_table: cover property ($changed(tab_hi_o));
endmodule // mtc_core_props

bind mtc_core mtc_core_props #(.PC_W(PC_W)) u_mtc_core_props (.ref_clk_i, .rst_i,
	.pm_addr_o, .dm_addr_o, .dm_we_o, .acc_o, .flags_o, .tab_hi_o, .retire_o);

// ---- mtc_core_regs.svh ----
`ifndef MTC_CORE_REGS_SVH
`define MTC_CORE_REGS_SVH

// System clocks in one machine cycle
`define MTC_MC_CLOCKS 4
// Data memory address that maps onto the program counter low byte
`define MTC_PC_LOW_ADDR 8'h02
// Reset values
`define MTC_PC_RST 10'h000
`define MTC_ACC_RST 8'h00
`define MTC_FLAGS_RST 4'h0
// Field positions of a program word when read as table data
`define MTC_TAB_LO_MSB 7
`define MTC_TAB_HI_LSB 8
`define MTC_TAB_HI_MSB 15

`endif

// ---- mtc_mem.sv ----
`timescale 1ns/1ps
module mtc_mem (
	// Clock
	input wire logic ref_clk_i,
	// Program side
	input wire logic [9:0] pm_addr_i,
	output mtc_pkg::mtc_insn_s pm_data_o,
	// Data side
	input wire logic [7:0] dm_addr_i,
	input wire logic [7:0] dm_wdata_i,
	input wire logic dm_we_i,
	output logic [7:0] dm_rdata_o
);
	mtc_pkg::mtc_insn_s pm [1024];
	logic [7:0] dm [256];
	// Asynchronous reads, always valid, so no stale bus state
	assign pm_data_o = pm[pm_addr_i];
	assign dm_rdata_o = dm[dm_addr_i];
	always @(posedge ref_clk_i) begin
		if (dm_we_i === 1'b1) begin
			dm[dm_addr_i] <= dm_wdata_i;
		end
	end
endmodule // mtc_mem

// ---- mtc_pkg.sv ----
package mtc_pkg;

	typedef enum logic [5:0] {
		OP_NOP, OP_MOV_A_M, OP_MOV_M_A, OP_MOV_A_X,
		OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADD_X, OP_SUB_X,
		OP_AND, OP_OR, OP_XOR, OP_AND_X, OP_OR_X, OP_XOR_X,
		OP_COMPLEMENT, OP_ADD_ONE, OP_SUB_ONE,
		OP_ROT_R, OP_ROT_L, OP_ROT_R_C, OP_ROT_L_C,
		OP_SET_BIT, OP_CLR_BIT, OP_CLR,
		OP_SKIP_ZERO, OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET,
		OP_JUMP, OP_CALL, OP_SUB_EXIT, OP_INT_EXIT, OP_TAB_READ
	} mtc_op_e;

	// Decoded program word: to_acc steers the result into the accumulator
	typedef struct packed {
		mtc_op_e op;
		logic to_acc;
		logic [2:0] bsel;
		logic [9:0] arg;
	} mtc_insn_s;

	typedef struct packed {
		logic ov;
		logic ac;
		logic c;
		logic z;
	} mtc_flags_s;

	typedef enum logic [1:0] {
		PH_FETCH = 2'b00,
		PH_DECODE = 2'b01,
		PH_OPERAND = 2'b11,
		PH_EXEC = 2'b10
	} mtc_phase_e;

endpackage

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [9:0] pm_addr;
	mtc_pkg::mtc_insn_s pm_data;
	logic [7:0] dm_addr, dm_wdata, dm_rdata, acc, tab_hi;
	logic dm_we, retire;
	mtc_pkg::mtc_flags_s flags;
	int num_errors = 0;
	int total_checks = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	mtc_core u_mtc_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pm_addr_o(pm_addr),
		.pm_data_i(pm_data), .dm_addr_o(dm_addr), .dm_wdata_o(dm_wdata), .dm_we_o(dm_we),
		.dm_rdata_i(dm_rdata), .acc_o(acc), .flags_o(flags), .tab_hi_o(tab_hi),
		.retire_o(retire));
	mtc_mem u_mtc_mem (.ref_clk_i(ref_clk_i), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
		.dm_addr_i(dm_addr), .dm_wdata_i(dm_wdata), .dm_we_i(dm_we), .dm_rdata_o(dm_rdata));
	////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Rest packs {to_acc, bit select, argument}
	task automatic ld(input logic [9:0] a, input mtc_pkg::mtc_op_e op, input logic [13:0] rest);
		u_mtc_mem.pm[a] = {op, rest};
	endtask
	task automatic rst_on();
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		for (int i = 0; i < 1024; i++) u_mtc_mem.pm[i] = '0;
		for (int i = 0; i < 256; i++) u_mtc_mem.dm[i] = 8'h00;
	endtask
	task automatic rst_off();
		repeat (3) @(negedge ref_clk_i);
		chk({acc, tab_hi}, 16'h0000);
		chk({flags, retire, dm_we, pm_addr}, 16'h0000);
		rst_i = 1'b0;
	endtask
	task automatic step(output int n);
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (retire !== 1'b1 && n < 20);
		if (retire !== 1'b1) begin
			num_errors++;
			test_done();
		end
	endtask
	////////////////////////////////////////
	task automatic s_alu();
		int n;
		logic [11:0] ex [11] = '{12'hf00, 12'h102, 12'hf02, 12'hf02, 12'he12, 12'he12,
			12'h003, 12'h003, 12'h003, 12'h053, 12'h053};
		rst_on();
		u_mtc_mem.dm[8'h41] = 8'h01;
		u_mtc_mem.dm[8'h42] = 8'h81;
		u_mtc_mem.pm[10'h305] = 20'h0a55a;
		ld(10'h000, mtc_pkg::OP_MOV_A_X, 14'h20f0);
		ld(10'h001, mtc_pkg::OP_ADD_X, 14'h2020);
		ld(10'h002, mtc_pkg::OP_SUB_X, 14'h2020);
		ld(10'h003, mtc_pkg::OP_MOV_M_A, 14'h0040);
		ld(10'h004, mtc_pkg::OP_ROT_L_C, 14'h2040);
		ld(10'h005, mtc_pkg::OP_ADD_ONE, 14'h0040);
		ld(10'h006, mtc_pkg::OP_AND_X, 14'h2000);
		ld(10'h007, mtc_pkg::OP_SUB_ONE, 14'h2041);
		ld(10'h008, mtc_pkg::OP_SET_BIT, 14'h0c42);
		ld(10'h009, mtc_pkg::OP_MOV_A_X, 14'h2005);
		ld(10'h00a, mtc_pkg::OP_TAB_READ, 14'h0043);
		rst_off();
		for (int i = 0; i < 11; i++) begin
			step(n);
			chk({acc, flags & 4'hb}, ex[i]);
		end
		@(negedge ref_clk_i);
		chk(u_mtc_mem.dm[8'h40], 8'hf1);
		chk(u_mtc_mem.dm[8'h42], 8'h89);
		chk({tab_hi, u_mtc_mem.dm[8'h43]}, 16'ha55a);
	endtask
	// Skipped and prefetched words load the accumulator if wrongly executed
	task automatic s_flow();
		int n;
		int ex [11] = '{4, 8, 4, 8, 8, 4, 8, 4, 4, 8, 4};
		rst_on();
		u_mtc_mem.dm[8'h21] = 8'h01;
		ld(10'h000, mtc_pkg::OP_MOV_A_X, 14'h2005);
		ld(10'h001, mtc_pkg::OP_CALL, 14'h0008);
		ld(10'h008, mtc_pkg::OP_ADD_X, 14'h2001);
		ld(10'h009, mtc_pkg::OP_SUB_EXIT, 14'h0000);
		ld(10'h002, mtc_pkg::OP_SKIP_ZERO, 14'h0020);
		ld(10'h003, mtc_pkg::OP_MOV_A_X, 14'h20ee);
		ld(10'h004, mtc_pkg::OP_SKIP_ZERO, 14'h0021);
		ld(10'h005, mtc_pkg::OP_JUMP, 14'h000c);
		ld(10'h006, mtc_pkg::OP_MOV_A_X, 14'h2099);
		ld(10'h00c, mtc_pkg::OP_MOV_M_A, 14'h0030);
		ld(10'h00d, mtc_pkg::OP_MOV_A_X, 14'h2010);
		ld(10'h00e, mtc_pkg::OP_MOV_M_A, 14'h0002);
		ld(10'h00f, mtc_pkg::OP_MOV_A_X, 14'h2077);
		ld(10'h010, mtc_pkg::OP_ADD_X, 14'h2000);
		rst_off();
		for (int i = 0; i < 11; i++) begin
			step(n);
			chk(n[15:0], ex[i][15:0]);
		end
		chk(acc, 8'h10);
		chk(u_mtc_mem.dm[8'h30], 8'h06);
	endtask
	// Flag arithmetic, memory forms and bit skips; trap words load 0xee
	task automatic s_ops();
		int n;
		logic [15:0] ex [20] = '{16'h43c0, 16'h44b4, 16'h4caa, 16'h4c90, 16'h44aa, 16'h44b0,
			16'h4001, 16'h43c0, 16'h4f00, 16'h4001, 16'h4403, 16'h4c03, 16'h4c03, 16'h4c03,
			16'h8c03, 16'h4c03, 16'h8c03, 16'h8c03, 16'h8c03, 16'h45a3};
		rst_on();
		u_mtc_mem.dm[8'h50] = 8'h3c;
		u_mtc_mem.dm[8'h51] = 8'h81;
		u_mtc_mem.dm[8'h52] = 8'h0f;
		ld(10'h000, mtc_pkg::OP_MOV_A_M, 14'h0050);
		ld(10'h001, mtc_pkg::OP_ADD, 14'h2052);
		ld(10'h002, mtc_pkg::OP_SUB, 14'h2051);
		ld(10'h003, mtc_pkg::OP_SBC, 14'h2053);
		ld(10'h004, mtc_pkg::OP_ADC, 14'h2051);
		ld(10'h005, mtc_pkg::OP_ADC, 14'h2053);
		ld(10'h006, mtc_pkg::OP_XOR_X, 14'h204b);
		ld(10'h007, mtc_pkg::OP_OR, 14'h2050);
		ld(10'h008, mtc_pkg::OP_COMPLEMENT, 14'h2052);
		ld(10'h009, mtc_pkg::OP_AND, 14'h2052);
		ld(10'h00a, mtc_pkg::OP_ROT_R_C, 14'h2051);
		ld(10'h00b, mtc_pkg::OP_ROT_R, 14'h2051);
		ld(10'h00c, mtc_pkg::OP_ROT_L, 14'h0051);
		ld(10'h00d, mtc_pkg::OP_CLR_BIT, 14'h0850);
		ld(10'h00e, mtc_pkg::OP_SKIP_BIT_SET, 14'h0c50);
		ld(10'h00f, mtc_pkg::OP_MOV_A_X, 14'h20ee);
		ld(10'h010, mtc_pkg::OP_SKIP_BIT_CLR, 14'h0c50);
		ld(10'h011, mtc_pkg::OP_SKIP_BIT_CLR, 14'h0850);
		ld(10'h012, mtc_pkg::OP_MOV_A_X, 14'h20ee);
		ld(10'h013, mtc_pkg::OP_CALL, 14'h0020);
		ld(10'h014, mtc_pkg::OP_MOV_A_X, 14'h205a);
		ld(10'h020, mtc_pkg::OP_INT_EXIT, 14'h0000);
		rst_off();
		for (int i = 0; i < 20; i++) begin
			step(n);
			chk({n[3:0], acc, flags}, ex[i]);
		end
		chk({u_mtc_mem.dm[8'h50], u_mtc_mem.dm[8'h51]}, 16'h3803);
		chk(u_mtc_mem.dm[8'h52], 8'h0f);
	endtask
	////////////////////////////////////////
	initial begin
		s_alu();
		s_flow();
		s_ops();
		test_done();
	end
endmodule // tb_top
